// ==== verilog/pmd_pkg.sv ====
// Package: register map, field positions and timing of the disable bank
package pmd_pkg;
	localparam logic [3:0]  ctl_1_offset     = 4'h0;
	localparam logic [15:0] ctl_1_reset      = 16'h0000;
	localparam int          addr_width       = 4;
	localparam int          timer_five_bit   = 15;
	localparam int          timer_four_bit   = 14;
	localparam int          timer_three_bit  = 13;
	localparam int          timer_two_bit    = 12;
	localparam int          timer_one_bit    = 11;
	localparam int          motor_pwm_bit    = 9;
	localparam int          i2c_port_bit     = 7;
	localparam int          uart_port_bit    = 5;
	localparam int          module_count     = 8;
	// Implemented-bit mask: 15..11, 9, 7, 5
	localparam logic [15:0] ctl_1_impl_mask  = 16'hFAA0;
	// Bits present only on the larger variant
	localparam logic [15:0] large_only_mask  = 16'hC000;
	localparam logic [31:0] unmapped_data    = 32'h00000000;
	// Delay from write to gate change, in instruction cycles
	localparam int          apply_delay_cyc  = 1;
endpackage : pmd_pkg

// ==== verilog/gate_stage.sv ====
// One-cycle delay stage from disable bits to clock enables
`timescale 1ns/1ps
module gate_stage
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [7:0]  disable_bits,
	output logic      [7:0]  clock_enable
);
	import pmd_pkg::*;

	// --------------------------------------------------------------
	// Registered enables
	// --------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < module_count; g++)
		begin : stage
			always_ff @(posedge mclk or posedge reset)
			begin
				if (reset)
					clock_enable[g] <= 1'b1;
				else
					clock_enable[g] <= ~disable_bits[g];
			end
		end
	endgenerate
endmodule : gate_stage

// ==== verilog/peripheral_module_disable_bank.sv ====
// Peripheral module disable bank with Avalon-MM register slave
// Functional notes
// - Bit 15 set disables the fifth timer, clear keeps it enabled.
// - Bit 14 set disables the fourth timer, clear keeps it enabled.
// - Bit 13 set disables the third timer, clear keeps it enabled.
// - Bit 12 set disables the second timer, clear enables it.
// - Bit 11 set disables the first timer, clear keeps it running.
// - The motor PWM is disabled while its bit (bit 9) holds one.
// - Bit 7 set disables the I2C port, clear enables it.
// - Bit 5 set disables the UART, clear lets it run.
// - Bits 10, 8, 6 and 4 read as zero and ignore writes.
// - A disabled module loses its clock and its register access.
// - A change of a disable bit acts one cycle after the write.
// - After reset all present modules are enabled.
// - Fourth and fifth timer bits exist only on the larger variant.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module peripheral_module_disable_bank
#(
	parameter bit has_timers_four_five = 1'b1
)
(
	input  wire logic                           mclk,
	input  wire logic                           reset,
	input  wire logic [pmd_pkg::addr_width-1:0] address,
	input  wire logic                           read,
	input  wire logic                           write,
	input  wire logic [31:0]                    writedata,
	input  wire logic [3:0]                     byteenable,
	output logic      [31:0]                    readdata,
	output logic                                waitrequest,
	output logic                                timer_five_clk_en,
	output logic                                timer_four_clk_en,
	output logic                                timer_three_clk_en,
	output logic                                timer_two_clk_en,
	output logic                                timer_one_clk_en,
	output logic                                motor_pwm_clk_en,
	output logic                                i2c_port_clk_en,
	output logic                                uart_port_clk_en,
	output logic                                timer_five_reg_en,
	output logic                                timer_four_reg_en,
	output logic                                timer_three_reg_en,
	output logic                                timer_two_reg_en,
	output logic                                timer_one_reg_en,
	output logic                                motor_pwm_reg_en,
	output logic                                i2c_port_reg_en,
	output logic                                uart_port_reg_en
);
	import pmd_pkg::*;

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	function automatic logic hits_ctl(input logic [addr_width-1:0] a);
		hits_ctl = (a == ctl_1_offset);
	endfunction : hits_ctl

	// Writable bits depend on the variant; absent timers stay clear
	localparam logic [15:0] writable_mask = has_timers_four_five ?
		ctl_1_impl_mask : (ctl_1_impl_mask & ~large_only_mask);

	logic [15:0] peripheral_disable_ctl_1;
	logic        answered;
	logic [15:0] lane_mask;
	logic [7:0]  disable_bits;
	logic [7:0]  clock_enable;

	assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

	// --------------------------------------------------------------
	// Bus handshake
	// --------------------------------------------------------------
	// One wait state: request seen, answer on the next edge
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			answered <= 1'b0;
		else if ((read || write) && !answered)
			answered <= 1'b1;
		else
			answered <= 1'b0;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			waitrequest <= 1'b1;
		else if ((read || write) && !answered && waitrequest)
			waitrequest <= 1'b0;
		else
			waitrequest <= 1'b1;
	end

	// --------------------------------------------------------------
	// Control register
	// --------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			peripheral_disable_ctl_1 <= ctl_1_reset;
		else if (write && !waitrequest && hits_ctl(address))
			peripheral_disable_ctl_1 <=
				(peripheral_disable_ctl_1 & ~(lane_mask & writable_mask)) |
				(writedata[15:0] & lane_mask & writable_mask);
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			readdata <= unmapped_data;
		else if (read && !answered && hits_ctl(address))
			readdata <= {16'h0000, peripheral_disable_ctl_1};
		else if (read && !answered)
			readdata <= unmapped_data;
	end

	// --------------------------------------------------------------
	// Gating
	// --------------------------------------------------------------
	assign disable_bits = {
		peripheral_disable_ctl_1[timer_five_bit],
		peripheral_disable_ctl_1[timer_four_bit],
		peripheral_disable_ctl_1[timer_three_bit],
		peripheral_disable_ctl_1[timer_two_bit],
		peripheral_disable_ctl_1[timer_one_bit],
		peripheral_disable_ctl_1[motor_pwm_bit],
		peripheral_disable_ctl_1[i2c_port_bit],
		peripheral_disable_ctl_1[uart_port_bit]
	};

	// Enables lag the register by one cycle
	gate_stage u_gate
	(
		.mclk         (mclk),
		.reset        (reset),
		.disable_bits (disable_bits),
		.clock_enable (clock_enable)
	);

	// Clock and register access share one gate so both drop together
	assign timer_five_clk_en  = clock_enable[7];
	assign timer_four_clk_en  = clock_enable[6];
	assign timer_three_clk_en = clock_enable[5];
	assign timer_two_clk_en   = clock_enable[4];
	assign timer_one_clk_en   = clock_enable[3];
	assign motor_pwm_clk_en   = clock_enable[2];
	assign i2c_port_clk_en    = clock_enable[1];
	assign uart_port_clk_en   = clock_enable[0];
	assign timer_five_reg_en  = clock_enable[7];
	assign timer_four_reg_en  = clock_enable[6];
	assign timer_three_reg_en = clock_enable[5];
	assign timer_two_reg_en   = clock_enable[4];
	assign timer_one_reg_en   = clock_enable[3];
	assign motor_pwm_reg_en   = clock_enable[2];
	assign i2c_port_reg_en    = clock_enable[1];
	assign uart_port_reg_en   = clock_enable[0];
endmodule : peripheral_module_disable_bank

// ==== tb/pmd_properties.sv ====
// Port checker for the peripheral disable bank
`timescale 1ns/1ps
module pmd_properties
(
	input wire logic        mclk, reset, read, write, waitrequest,
	input wire logic [3:0]  address, byteenable,
	input wire logic [31:0] writedata, readdata,
	input wire logic        timer_five_clk_en, timer_four_clk_en,
	input wire logic        timer_three_clk_en, timer_two_clk_en,
	input wire logic        timer_one_clk_en, motor_pwm_clk_en,
	input wire logic        i2c_port_clk_en, uart_port_clk_en
);
	wire [7:0] en = {timer_five_clk_en, timer_four_clk_en,
		timer_three_clk_en, timer_two_clk_en, timer_one_clk_en,
		motor_pwm_clk_en, i2c_port_clk_en, uart_port_clk_en};
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence hi_acc;
		write && !waitrequest && address == 4'h0 && byteenable[1];
	endsequence
	sequence lo_acc;
		write && !waitrequest && address == 4'h0 && byteenable[0];
	endsequence
	t5_gate_a: assert property (hi_acc |-> ##2 en[7] == !$past(writedata[15], 2))
		else $error("timer five gate wrong");
	t4_gate_a: assert property (hi_acc |-> ##2 en[6] == !$past(writedata[14], 2))
		else $error("timer four gate wrong");
	t3_gate_a: assert property (hi_acc |-> ##2 en[5] == !$past(writedata[13], 2))
		else $error("timer three gate wrong");
	t2_gate_a: assert property (hi_acc |-> ##2 en[4] == !$past(writedata[12], 2))
		else $error("timer two gate wrong");
	t1_gate_a: assert property (hi_acc |-> ##2 en[3] == !$past(writedata[11], 2))
		else $error("timer one gate wrong");
	pwm_gate_a: assert property (hi_acc |-> ##2 en[2] == !$past(writedata[9], 2))
		else $error("pwm gate wrong");
	i2c_gate_a: assert property (lo_acc |-> ##2 en[1] == !$past(writedata[7], 2))
		else $error("i2c gate wrong");
	uart_gate_a: assert property (lo_acc |-> ##2 en[0] == !$past(writedata[5], 2))
		else $error("uart gate wrong");
	rsv_zero_a: assert property (read && !waitrequest |-> (readdata & 32'hFFFF0550) == 32'h0)
		else $error("reserved bits read nonzero");
	reset_on_a: assert property ($past(reset) |-> en == 8'hFF)
		else $error("enables low after reset");
endmodule : pmd_properties
bind peripheral_module_disable_bank pmd_properties u_chk (.*);

// ==== tb/peripheral_model.sv ====
// Far-side peripherals: each flag toggles on every enabled clock
`timescale 1ns/1ps
module peripheral_model
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [7:0] clk_en,
	output logic      [7:0] ticks
);
	// A gated module freezes, so its flag stops toggling
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			ticks <= 8'h00;
		else
			ticks <= ticks ^ clk_en;
	end
endmodule : peripheral_model

// ==== tb/tb.sv ====
// Self-checking bench for the peripheral disable bank
`timescale 1ns/1ps
module tb;
	import pmd_pkg::*;
	logic mclk = 0, reset = 1, read = 0, write = 0, waitrequest;
	logic [3:0] address = 4'h0, byteenable = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, rd;
	wire  [7:0] en, ren;
	logic [7:0] ticks, snap;
	int mismatches = 0, comparisons = 0, cycles = 0;
	int pos[8] = '{15, 14, 13, 12, 11, 9, 7, 5};
	peripheral_module_disable_bank DUT (.mclk(mclk), .reset(reset),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.timer_five_clk_en(en[7]), .timer_four_clk_en(en[6]),
		.timer_three_clk_en(en[5]), .timer_two_clk_en(en[4]),
		.timer_one_clk_en(en[3]), .motor_pwm_clk_en(en[2]),
		.i2c_port_clk_en(en[1]), .uart_port_clk_en(en[0]),
		.timer_five_reg_en(ren[7]), .timer_four_reg_en(ren[6]),
		.timer_three_reg_en(ren[5]), .timer_two_reg_en(ren[4]),
		.timer_one_reg_en(ren[3]), .motor_pwm_reg_en(ren[2]),
		.i2c_port_reg_en(ren[1]), .uart_port_reg_en(ren[0]));
	peripheral_model far (.mclk(mclk), .reset(reset), .clk_en(en),
		.ticks(ticks));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic report_and_stop();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic test_reset();
		bus(1'b0, 4'h0, 32'h0, 4'h3);
		check(rd, 32'h0);
		check(en, 8'hFF);
		$display("reset state done");
	endtask : test_reset
	// Expected enables kept to eight bits: a bare invert would set 31:8
	task automatic test_bit_walk();
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, 4'h0, 32'h1 << pos[i], 4'h3);
			@(posedge mclk);
			#1 check(en, 32'hFF & ~(32'h80 >> i));
			bus(1'b0, 4'h0, 32'h0, 4'h3);
			check(rd, 32'h1 << pos[i]);
		end
		$display("bit walk done");
	endtask : test_bit_walk
	task automatic test_gating_lanes();
		bus(1'b1, 4'h0, 32'h0000FFFF, 4'h3);
		bus(1'b0, 4'h0, 32'h0, 4'h3);
		check(rd, 32'h0000FAA0);
		snap = ticks;
		repeat (4) @(posedge mclk);
		check(ticks, snap);
		check(ren, 8'h00);
		bus(1'b1, 4'h0, 32'h0, 4'h1);
		bus(1'b1, 4'h1, 32'h0, 4'h3);
		bus(1'b0, 4'h1, 32'h0, 4'h3);
		check(rd, 32'h0);
		bus(1'b0, 4'h0, 32'h0, 4'h3);
		check(rd, 32'h0000FA00);
		$display("gating and lanes done");
	endtask : test_gating_lanes
	// Register holds 16'hFA00 here: only the I2C and UART gates are open
	task automatic test_clear_timing();
		bus(1'b1, 4'h0, 32'h0, 4'h3);
		#1 check(en, 8'h03);
		@(posedge mclk);
		#1 check(en, 8'hFF);
		check(ren, 8'hFF);
		snap = ticks;
		@(posedge mclk);
		#1 check(ticks, 8'hFF ^ snap);
		$display("clear timing done");
	endtask : test_clear_timing
	task automatic test_reset_again();
		bus(1'b1, 4'h0, 32'h0000FFFF, 4'h3);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		#1 check(en, 8'hFF);
		check(ren, 8'hFF);
		bus(1'b0, 4'h0, 32'h0, 4'h3);
		check(rd, 32'h0);
		$display("reset again done");
	endtask : test_reset_again
	initial
	begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		test_reset();
		test_bit_walk();
		test_gating_lanes();
		test_clear_timing();
		test_reset_again();
		report_and_stop();
	end
endmodule : tb
